// File: bss_pkg.sv
package bss_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [3:0] BSS_STATUS_OFS  = 4'h0;  // Boot decision and run state
    localparam logic [3:0] BSS_CONTROL_OFS = 4'h4;  // Application core release
    localparam logic [3:0] BSS_STRAPS_OFS  = 4'h8;  // Captured raw inputs

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BSS_ST_MODE_LO   = 0;  // Boot mode, two bits
    localparam int BSS_ST_FUSE      = 2;  // Fuses chose the source
    localparam int BSS_ST_CARD_SD   = 3;  // Card type is SD
    localparam int BSS_ST_PORT_ONE  = 4;  // Card host port one
    localparam int BSS_ST_USB_HOST  = 5;  // USB routed to hub
    localparam int BSS_ST_MCU_RUN   = 6;  // Microcontroller core running
    localparam int BSS_ST_APP_RUN   = 7;  // Application core running
    localparam int BSS_ST_SAMPLED   = 8;  // Boot inputs captured
    localparam int BSS_ST_MCU_FLASH = 9;  // MCU image from serial flash
    localparam int BSS_ST_APP_CARD  = 10; // App image from card storage
    localparam int BSS_CT_RELEASE   = 0;  // Write one to release app core

    // ************************************************************
    // Reset values and answers
    // ************************************************************
    localparam logic [31:0] BSS_ZERO_WORD  = 32'h0000_0000;
    localparam logic [1:0]  BSS_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  BSS_RESP_SLVER = 2'h2;

    // ************************************************************
    // Timing: cycles of input settling after reset release
    // ************************************************************
    localparam logic [1:0]  BSS_SETTLE_CYC = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        BSS_MODE_DUAL,
        BSS_MODE_SINGLE,
        BSS_MODE_LOW_POWER,
        BSS_MODE_SERIAL
    } bss_mode_e;

    typedef enum logic [1:0] {
        BSS_SEQ_SETTLE,
        BSS_SEQ_MCU_ONLY,
        BSS_SEQ_BOTH,
        BSS_SEQ_APP_ONLY
    } bss_seq_e;

endpackage

// File: bss_boot_source_select.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module bss_boot_source_select
    import bss_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    // Same clock, no synchronisers
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Board pins, floating reads high through pull-ups
    // All of them cross into aclk through two flops
    input  wire logic        boot_source_select,
    input  wire logic        serial_download_request,
    input  wire logic        card_type_strap,
    input  wire logic        host_port_strap,
    input  wire logic        dual_memory_strap,
    input  wire logic        low_power_boot_strap,
    input  wire logic        usb_route_select,
    // Fuse bank
    // Static once programmed, still synchronised
    input  wire logic        fuse_boot_enable,
    input  wire logic [3:0]  fuse_boot_cfg,
    // Boot decision outputs
    // Valid from the edge after capture
    output logic             mcu_core_run,
    output logic             app_core_run,
    output logic [1:0]       boot_mode,
    output logic             mcu_from_flash,
    output logic             app_from_card,
    output logic             card_is_sd,
    output logic             card_host_port_one,
    output logic             usb_to_host,
    output logic             boot_from_fuses
);

    // ************************************************************
    // State
    // ************************************************************
    // Whole block state; one comb process fills the
    // copy and one flop stage holds it
    typedef struct packed {
        logic [11:0] sync1;      // First synchroniser stage
        logic [11:0] sync2;      // Second synchroniser stage
        logic [11:0] captured;   // Inputs frozen at boot
        logic [1:0]  settle;     // Settling counter
        bss_seq_e    seq;        // Core sequencing state
        bss_mode_e   mode;       // Decided boot mode
        logic        fuse_used;  // Fuses chose the source
        logic        card_sd;    // Card type
        logic        port_one;   // Card host port
        logic        usb_host;   // USB route
        logic        mcu_flash;  // MCU image source
        logic        app_card;   // App image source
        logic        mcu_run;    // MCU core run
        logic        app_run;    // App core run
        logic        awready;    // Write address ready
        logic        wready;     // Write data ready
        logic        have_aw;    // Address held
        logic        have_w;     // Data held
        logic [3:0]  awaddr;     // Held write address
        logic [31:0] wdata;      // Held write data
        logic [3:0]  wstrb;      // Held strobes
        logic        bvalid;     // Write response valid
        logic [1:0]  bresp;      // Write response code
        logic        arready;    // Read address ready
        logic        rvalid;     // Read data valid
        logic [31:0] rdata;      // Read data
        logic [1:0]  rresp;      // Read response code
    } bss_state_s;

    bss_state_s cur;             // Registered state
    bss_state_s next_cur;        // Next state

    // Combinational helpers
    logic [11:0] raw_in;         // Gathered asynchronous inputs
    logic        c_sel;          // Captured boot source select
    logic        c_req;          // Captured download request
    logic        c_fen;          // Captured fuse enable
    logic [3:0]  c_fcfg;         // Captured fuse config
    logic [3:0]  c_strap;        // Captured straps
    logic [3:0]  cfg;            // Straps or fuses in use
    logic [31:0] status_word;    // Status register image
    logic        do_write;       // Write completes this cycle

    // Pins gathered, select in bit 0, fuses on top
    assign raw_in = {
        fuse_boot_cfg,
        fuse_boot_enable,
        usb_route_select,
        low_power_boot_strap,
        dual_memory_strap,
        host_port_strap,
        card_type_strap,
        serial_download_request,
        boot_source_select
    };

    // Field views of captured inputs, same order
    assign c_sel   = cur.captured[0];
    assign c_req   = cur.captured[1];
    assign c_strap = cur.captured[5:2];
    assign c_fen   = cur.captured[7];
    assign c_fcfg  = cur.captured[11:8];

    // ************************************************************
    // Status image
    // ************************************************************
    // Read data copies this when a status read is taken
    always_comb begin
        // Unused bits read as zero
        status_word = BSS_ZERO_WORD;
        status_word[BSS_ST_MODE_LO +: 2] = cur.mode;
        status_word[BSS_ST_FUSE]         = cur.fuse_used;
        status_word[BSS_ST_CARD_SD]      = cur.card_sd;
        status_word[BSS_ST_PORT_ONE]     = cur.port_one;
        status_word[BSS_ST_USB_HOST]     = cur.usb_host;
        status_word[BSS_ST_MCU_RUN]      = cur.mcu_run;
        status_word[BSS_ST_APP_RUN]      = cur.app_run;
        status_word[BSS_ST_SAMPLED]      = (cur.seq != BSS_SEQ_SETTLE);
        status_word[BSS_ST_MCU_FLASH]    = cur.mcu_flash;
        status_word[BSS_ST_APP_CARD]     = cur.app_card;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    // Boot sequencing first, then the write and read channels
    always_comb begin
        // Defaults: hold state, no write this cycle
        next_cur = cur;
        cfg      = 4'h0;
        do_write = 1'b0;

        // Two-stage synchroniser; only the second stage
        // feeds the capture, so no half-settled level is frozen
        next_cur.sync1 = raw_in;
        next_cur.sync2 = cur.sync1;

        // Boot sequencing
        // Settle, capture, decide, then wait or run
        case (cur.seq)
            BSS_SEQ_SETTLE: begin
                // Wait for synchronised inputs, then freeze once
                // Later pin changes are ignored until reset
                if (cur.settle == BSS_SETTLE_CYC) begin
                    next_cur.captured = cur.sync2;
                    next_cur.seq      = BSS_SEQ_MCU_ONLY;
                    next_cur.mcu_run  = 1'b1;
                end else begin
                    next_cur.settle = cur.settle + 2'h1;
                end
            end
            BSS_SEQ_MCU_ONLY: begin
                // MCU alone decides; straps or fuses give the config
                // Request low wins; a fuse path without its
                // enable bit falls back to download
                // Low-power takes priority over dual memory
                next_cur.fuse_used = c_req && c_sel;
                cfg = next_cur.fuse_used ? c_fcfg : c_strap;
                next_cur.card_sd  = cfg[0];
                next_cur.port_one = cfg[1];
                next_cur.usb_host = cur.captured[6];
                if (!c_req || (next_cur.fuse_used && !c_fen)) begin
                    // Recovery download: app core only, MCU idle
                    next_cur.mode      = BSS_MODE_SERIAL;
                    next_cur.mcu_flash = 1'b0;
                    next_cur.app_card  = 1'b0;
                    next_cur.mcu_run   = 1'b0;
                    next_cur.app_run   = 1'b1;
                    next_cur.seq       = BSS_SEQ_APP_ONLY;
                end else if (cfg[3]) begin
                    // Low-power: MCU from flash, app on demand
                    next_cur.mode      = BSS_MODE_LOW_POWER;
                    next_cur.mcu_flash = 1'b1;
                    next_cur.app_card  = 1'b1;
                    next_cur.seq       = BSS_SEQ_BOTH;
                end else if (cfg[2]) begin
                    // Dual memory: MCU from flash, app from card
                    next_cur.mode      = BSS_MODE_DUAL;
                    next_cur.mcu_flash = 1'b1;
                    next_cur.app_card  = 1'b1;
                    next_cur.seq       = BSS_SEQ_BOTH;
                end else begin
                    // Single memory: both images from card
                    next_cur.mode      = BSS_MODE_SINGLE;
                    next_cur.mcu_flash = 1'b0;
                    next_cur.app_card  = 1'b1;
                    next_cur.seq       = BSS_SEQ_BOTH;
                end
            end
            BSS_SEQ_BOTH: begin
                // App held until MCU software releases it, see write path
                // The release bit acts in this state only
            end
            default: begin
                // Serial download, nothing more to do
                // Release writes change nothing here
            end
        endcase

        // Either half may come first and waits in its
        // holding register for the other
        // Write address channel
        if (s_axi_awvalid && cur.awready) begin
            next_cur.have_aw = 1'b1;
            next_cur.awaddr  = s_axi_awaddr;
        end
        // Write data channel
        if (s_axi_wvalid && cur.wready) begin
            next_cur.have_w = 1'b1;
            next_cur.wdata  = s_axi_wdata;
            next_cur.wstrb  = s_axi_wstrb;
        end
        // Response retires
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end
        // Both halves held: perform write
        // Unmapped offsets answer with a slave error
        if (cur.have_aw && cur.have_w && !cur.bvalid) begin
            do_write         = 1'b1;
            next_cur.have_aw = 1'b0;
            next_cur.have_w  = 1'b0;
            next_cur.bvalid  = 1'b1;
            next_cur.bresp   = BSS_RESP_OKAY;
            if (cur.awaddr[3:2] == BSS_CONTROL_OFS[3:2]) begin
                // Release only from the MCU-first wait state
                // Only bit 0 of byte lane 0 counts
                if (cur.wstrb[0] && cur.wdata[BSS_CT_RELEASE]
                        && cur.seq == BSS_SEQ_BOTH) begin
                    next_cur.app_run = 1'b1;
                end
            end else if (cur.awaddr[3:2] == BSS_STATUS_OFS[3:2]) begin
                // Read-only, write ignored
            end else if (cur.awaddr[3:2] == BSS_STRAPS_OFS[3:2]) begin
                // Read-only, write ignored
            end else begin
                next_cur.bresp = BSS_RESP_SLVER;
            end
        end
        // Each ready stays low while its own half is held or a
        // response waits: one write in flight
        next_cur.awready = !next_cur.have_aw && !next_cur.bvalid && !do_write;
        next_cur.wready  = !next_cur.have_w && !next_cur.bvalid && !do_write;

        // Read channel
        // Data is frozen when the address is taken and
        // stands until rready
        if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        if (s_axi_arvalid && cur.arready) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp  = BSS_RESP_OKAY;
            if (s_axi_araddr[3:2] == BSS_STATUS_OFS[3:2]) begin
                next_cur.rdata = status_word;
            end else if (s_axi_araddr[3:2] == BSS_CONTROL_OFS[3:2]) begin
                next_cur.rdata = {31'h0, cur.app_run};
            end else if (s_axi_araddr[3:2] == BSS_STRAPS_OFS[3:2]) begin
                // Frozen pin levels, not the live pins
                next_cur.rdata = {20'h0, cur.captured};
            end else begin
                next_cur.rdata = BSS_ZERO_WORD;
                next_cur.rresp = BSS_RESP_SLVER;
            end
        end
        // Next address only once the data has retired
        next_cur.arready = !next_cur.rvalid;
    end

    // ************************************************************
    // State register, synchronous active-low reset
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Both cores held and the decision cleared
            cur         <= '0;
            cur.seq     <= BSS_SEQ_SETTLE;
            cur.mode    <= BSS_MODE_DUAL;
            cur.bresp   <= BSS_RESP_OKAY;
            cur.rresp   <= BSS_RESP_OKAY;
        end else begin
            // Every register runs on every edge
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs straight from flops
    // ************************************************************
    // Register bus
    assign s_axi_awready      = cur.awready;
    assign s_axi_wready       = cur.wready;
    assign s_axi_bresp        = cur.bresp;
    assign s_axi_bvalid       = cur.bvalid;
    assign s_axi_arready      = cur.arready;
    assign s_axi_rdata        = cur.rdata;
    assign s_axi_rresp        = cur.rresp;
    assign s_axi_rvalid       = cur.rvalid;

    // Boot decision
    assign mcu_core_run       = cur.mcu_run;
    assign app_core_run       = cur.app_run;
    assign boot_mode          = cur.mode;
    assign mcu_from_flash     = cur.mcu_flash;
    assign app_from_card      = cur.app_card;
    assign card_is_sd         = cur.card_sd;
    assign card_host_port_one = cur.port_one;
    assign usb_to_host        = cur.usb_host;
    assign boot_from_fuses    = cur.fuse_used;

endmodule

// File: bss_props.sv
`timescale 1ns/10ps
// ****************
// Boot decision checker
// ****************
module bss_props
    import bss_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_bvalid,
    input wire logic       mcu_core_run,
    input wire logic       app_core_run,
    input wire logic [1:0] boot_mode,
    input wire logic       mcu_from_flash,
    input wire logic       app_from_card,
    input wire logic       card_is_sd,
    input wire logic       card_host_port_one,
    input wire logic       usb_to_host,
    input wire logic       boot_from_fuses
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [3:0] since_rel;  // Cycles since release, saturating
    logic       decided;    // Decision surely settled

    // Count cycles after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_rel <= 4'h0;
        end else if (since_rel != 4'hf) begin
            since_rel <= since_rel + 4'h1;
        end
    end
    assign decided = (since_rel >= 4'h8);

    chk_both_held: assert property (
        since_rel < 4'h4 |-> !mcu_core_run && !app_core_run)
        else $error("core released during settling");
    chk_app_after_mcu: assert property (
        app_core_run && boot_mode != BSS_MODE_SERIAL |-> mcu_core_run)
        else $error("app core running without mcu core");
    chk_release_write: assert property (
        $rose(app_core_run) && boot_mode != BSS_MODE_SERIAL |-> $rose(s_axi_bvalid))
        else $error("app core released without control write");
    chk_serial_idle: assert property (
        boot_mode == BSS_MODE_SERIAL |-> !mcu_core_run && app_core_run)
        else $error("serial mode core states wrong");
    chk_dual_split: assert property (
        decided && boot_mode == BSS_MODE_DUAL
        |-> mcu_from_flash && app_from_card && mcu_core_run)
        else $error("dual mode image sources wrong");
    chk_single_card: assert property (
        boot_mode == BSS_MODE_SINGLE |-> !mcu_from_flash && app_from_card && mcu_core_run)
        else $error("single mode image sources wrong");
    chk_lowpwr_flash: assert property (
        boot_mode == BSS_MODE_LOW_POWER |-> mcu_from_flash && mcu_core_run)
        else $error("low power mode mcu source wrong");
    chk_choice_held: assert property (
        decided && $past(decided) |-> $stable({boot_mode, card_is_sd,
        card_host_port_one, usb_to_host, boot_from_fuses, mcu_from_flash, app_from_card}))
        else $error("boot decision changed after capture");
    chk_app_sticky: assert property (app_core_run |=> app_core_run)
        else $error("app core dropped without reset");
endmodule

bind bss_boot_source_select bss_props chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .mcu_core_run(mcu_core_run), .app_core_run(app_core_run), .boot_mode(boot_mode),
    .mcu_from_flash(mcu_from_flash), .app_from_card(app_from_card), .card_is_sd(card_is_sd),
    .card_host_port_one(card_host_port_one), .usb_to_host(usb_to_host),
    .boot_from_fuses(boot_from_fuses)
);

// File: bss_board_model.sv
`timescale 1ns/10ps
// ****************
// Carrier jumpers, sliders and fuse bank
// ****************
module bss_board_model (
    input  wire logic       select_grounded,  // Boot control jumper fitted
    input  wire logic       request_grounded, // Download jumper fitted
    input  wire logic [4:0] sliders,          // Usb, lowpwr, dual, port, card
    input  wire logic       fuse_en_bit,      // Programmed fuse enable
    input  wire logic [3:0] fuse_cfg_bits,    // Programmed fuse config
    output logic            boot_source_select,
    output logic            serial_download_request,
    output logic            card_type_strap,
    output logic            host_port_strap,
    output logic            dual_memory_strap,
    output logic            low_power_boot_strap,
    output logic            usb_route_select,
    output logic            fuse_boot_enable,
    output logic [3:0]      fuse_boot_cfg
);
    // Open jumper floats high through pull-up
    assign boot_source_select      = !select_grounded;
    assign serial_download_request = !request_grounded;
    // Straps come only from the sliders, held steady across reset
    assign {usb_route_select, low_power_boot_strap, dual_memory_strap,
            host_port_strap, card_type_strap} = sliders;
    // Fuses hold what was programmed
    assign fuse_boot_enable = fuse_en_bit;
    assign fuse_boot_cfg    = fuse_cfg_bits;
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import bss_pkg::*;
    // ****************
    // Signals
    // ****************
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, sel_gnd, req_gnd, fen;
    logic [3:0]  awaddr, araddr, wstrb, fcfg;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, boot_mode;
    logic [4:0]  sliders;
    logic        mcu_run, app_run, flash, card, sd, port1, usb_h, fuses;
    wire         bsel, sreq, card_s, port_s, dual_s, lp_s, usb_s, fen_p;
    wire  [3:0]  fcfg_p;
    wire  [10:0] outs = {card, flash, 1'b1, app_run, mcu_run, usb_h, port1, sd, fuses, boot_mode};
    int          n_mismatch, samples_checked;

    bss_board_model board_u (.select_grounded(sel_gnd), .request_grounded(req_gnd),
        .sliders(sliders), .fuse_en_bit(fen), .fuse_cfg_bits(fcfg),
        .boot_source_select(bsel), .serial_download_request(sreq), .card_type_strap(card_s),
        .host_port_strap(port_s), .dual_memory_strap(dual_s), .low_power_boot_strap(lp_s),
        .usb_route_select(usb_s), .fuse_boot_enable(fen_p), .fuse_boot_cfg(fcfg_p));
    bss_boot_source_select dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .boot_source_select(bsel), .serial_download_request(sreq), .card_type_strap(card_s),
        .host_port_strap(port_s), .dual_memory_strap(dual_s), .low_power_boot_strap(lp_s),
        .usb_route_select(usb_s), .fuse_boot_enable(fen_p), .fuse_boot_cfg(fcfg_p),
        .mcu_core_run(mcu_run), .app_core_run(app_run), .boot_mode(boot_mode),
        .mcu_from_flash(flash), .app_from_card(card), .card_is_sd(sd),
        .card_host_port_one(port1), .usb_to_host(usb_h), .boot_from_fuses(fuses));

    // ****************
    // Shared tasks
    // ****************
    task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Write: both halves offered together, bready held until bvalid
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Set board, reset, wait past the capture point
    task automatic boot(input logic s, input logic q, input logic [4:0] sl,
                        input logic fe, input logic [3:0] fc);
        @(posedge aclk);
        sel_gnd <= s; req_gnd <= q; sliders <= sl; fen <= fe; fcfg <= fc; aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (12) @(posedge aclk);
    endtask
    // Ports and status word against expected, masked
    task automatic check_state(input logic [10:0] e, input logic [10:0] m);
        logic [31:0] d;
        logic [1:0]  r;
        chk_val("outputs", {21'h0, e & m}, {21'h0, outs & m});
        axi_rd(BSS_STATUS_OFS, d, r);
        chk_val("status", {21'h0, e & m}, d & {21'h0, m});
        chk_val("status resp", {30'h0, BSS_RESP_OKAY}, {30'h0, r});
    endtask
    task automatic release_app(input logic [10:0] e, input logic [10:0] m);
        logic [1:0] r;
        axi_wr(BSS_CONTROL_OFS, 32'h0000_0001, r);
        chk_val("release resp", {30'h0, BSS_RESP_OKAY}, {30'h0, r});
        check_state(e, m);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic sc_dual();
        logic [31:0] d;
        logic [1:0]  r;
        boot(1'b1, 1'b0, 5'b00100, 1'b0, 4'h0);
        check_state(11'h740, 11'h7ff);
        release_app(11'h7c0, 11'h7ff);
        axi_rd(BSS_CONTROL_OFS, d, r);
        chk_val("control", 32'h0000_0001, d);
    endtask
    task automatic sc_straps();
        logic [31:0] d;
        logic [1:0]  r;
        boot(1'b1, 1'b0, 5'b10011, 1'b0, 4'h0);
        check_state(11'h579, 11'h7ff);
        @(posedge aclk);
        sliders <= 5'b01100; req_gnd <= 1'b1; sel_gnd <= 1'b0; fen <= 1'b1;
        repeat (10) @(posedge aclk);
        check_state(11'h579, 11'h7ff);
        axi_rd(BSS_STRAPS_OFS, d, r);
        chk_val("straps", 32'h0000_004e, d);
    endtask
    task automatic sc_lowpwr();
        boot(1'b1, 1'b0, 5'b01100, 1'b0, 4'h0);
        check_state(11'h742, 11'h7ff);
        release_app(11'h7c2, 11'h7ff);
    endtask
    task automatic sc_fuse();
        boot(1'b0, 1'b0, 5'b00001, 1'b1, 4'h6);
        check_state(11'h754, 11'h7ff);
        boot(1'b0, 1'b0, 5'b00100, 1'b0, 4'h6);
        check_state(11'h183, 11'h1e3);
    endtask
    task automatic sc_serial();
        logic [31:0] d;
        logic [1:0]  r;
        for (int s = 0; s < 2; s++) begin
            boot(s[0], 1'b1, 5'b00100, 1'b1, 4'h6);
            check_state(11'h183, 11'h1e3);
            release_app(11'h183, 11'h1e3);
        end
        axi_rd(4'hc, d, r);
        chk_val("unmapped resp", {30'h0, BSS_RESP_SLVER}, {30'h0, r});
        chk_val("unmapped data", BSS_ZERO_WORD, d);
        axi_wr(4'hc, 32'h0000_0001, r);
        chk_val("unmapped wresp", {30'h0, BSS_RESP_SLVER}, {30'h0, r});
    endtask

    // ****************
    // Clock, watchdog, main sequence
    // ****************
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        repeat (3000) @(posedge aclk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        n_mismatch = 0; samples_checked = 0; aresetn = 1'b0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0;
        sel_gnd = 1'b1; req_gnd = 1'b0; sliders = 5'b00100; fen = 1'b0; fcfg = 4'h0;
        sc_dual();
        sc_straps();
        sc_lowpwr();
        sc_fuse();
        sc_serial();
        wrap_up();
    end
endmodule
